// ### hw/aps_pkg.sv
// Shared constants and types for the converter power-mode sequencer
package aps_pkg;
   // ==========================================================
   // Frame geometry
   localparam int APS_CNT_W = 5;
   localparam logic [4:0] APS_EDGE_MIN = 5'h02;
   localparam logic [4:0] APS_EDGE_KEEP = 5'h0a;
   localparam logic [4:0] APS_EDGE_TRACK = 5'h0d;
   localparam logic [4:0] APS_EDGE_LAST = 5'h0f;
   localparam logic [4:0] APS_EDGE_FRAME = 5'h10;
   localparam int APS_RES_W = 12;
   localparam int APS_WORD_W = 16;
   localparam logic [3:0] APS_LEAD_ZEROS = 4'h0;
   // ==========================================================
   // Timing
   localparam int APS_CLK_MHZ = 125;
   localparam int APS_PART_WAKE_NS = 1000;
   localparam int APS_PART_WAKE_CYC = (APS_PART_WAKE_NS * APS_CLK_MHZ + 999) / 1000;
   localparam int APS_FULL_WAKE_US = 650;
   localparam int APS_FULL_WAKE_CYC = APS_FULL_WAKE_US * APS_CLK_MHZ;
   localparam int APS_WAKE_W = 17;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      APS_NORMAL,
      APS_PARTIAL,
      APS_FULL
   } aps_mode_e;

   typedef struct packed {
      aps_mode_e mode;
      logic analog_on;
      logic track;
      logic ready;
      logic frame_ok;
   } aps_status_s;
endpackage : aps_pkg

// ### hw/aps_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module aps_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta_r <= RST_VAL;
         o_q <= RST_VAL;
      end
      else
      begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule : aps_sync

// ### hw/aps_link.sv
// Serial-clock domain: frame edge counter and result shifter
`timescale 1ns/10ps
module aps_link (
   input wire logic i_sclk,
   input wire logic i_cs_b,
   input wire logic [aps_pkg::APS_WORD_W-1:0] i_word,
   output logic [aps_pkg::APS_CNT_W-1:0] o_cnt_gray,
   output logic o_sdo
);
   import aps_pkg::*;

   logic [APS_CNT_W-1:0] cnt_r;
   logic [APS_CNT_W-1:0] cnt_nxt;
   logic [3:0] bit_idx;

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (cnt_r != APS_EDGE_FRAME)
         cnt_nxt = cnt_r + 5'h01;
      bit_idx = 4'(APS_EDGE_LAST - 5'h01 - cnt_r);
   end

   // ==========================================================
   // Select high ends the frame; no sclk edge is needed to clear
   always_ff @(negedge i_sclk or posedge i_cs_b)
   begin
      if (i_cs_b)
      begin
         cnt_r <= '0;
         o_cnt_gray <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         o_cnt_gray <= cnt_nxt ^ (cnt_nxt >> 1);
      end
   end

   // First leading zero stands from select fall; edge k gives bit 15-k
   always_ff @(negedge i_sclk or posedge i_cs_b)
   begin
      if (i_cs_b)
         o_sdo <= 1'b0;
      else if (cnt_r < APS_EDGE_LAST)
         o_sdo <= i_word[bit_idx];
      else
         o_sdo <= 1'b0;
   end
endmodule : aps_link

// ### hw/aps_top.sv
// Power-mode sequencer of a serial sampling converter
`timescale 1ns/10ps
//
// Contract
// - Three modes only, chosen by where select rises within a frame.
// - Select falling samples the input and starts a frame.
// - Rise between edges ten and sixteen: stay powered, abort, float output.
// - A full frame with readout takes sixteen serial clocks.
// - From normal, rise between edges two and ten enters partial power-down.
// - From normal, rise before edge two keeps normal mode.
// - Wake frame held past edge ten powers up; next frame is valid.
// - From partial, rise before edge two returns to partial.
// - From partial, rise between edges two and ten enters full power-down.
// - Partial wake completes in about one microsecond.
// - Waking, track resumes on first serial clock edge after select falls.
// - Start-up mode is arbitrary; one dummy frame is advised.
// - At start-up the track-and-hold is already tracking.
// - Result word is four zeros then twelve bits, MSB first.
// - First zero at select fall, later bits on successive falling edges.
// - Output floats on the sixteenth falling edge of a full frame.
// - After thirteen falling edges, track resumes on the next rising edge.
module aps_top #(
   parameter int FULL_WAKE_CYC = aps_pkg::APS_FULL_WAKE_CYC,
   parameter aps_pkg::aps_mode_e POWERON_MODE = aps_pkg::APS_NORMAL
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_sclk,
   input wire logic i_cs_b,
   input wire logic [aps_pkg::APS_RES_W-1:0] i_result,
   output logic o_serial_result_out,
   output logic o_serial_result_oe,
   output aps_pkg::aps_status_s o_status,
   output logic o_sample,
   output logic o_abort
);
   import aps_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [APS_CNT_W-1:0] gray2bin(input logic [APS_CNT_W-1:0] g);
      logic [APS_CNT_W-1:0] b;
      b[APS_CNT_W-1] = g[APS_CNT_W-1];
      for (int i = APS_CNT_W - 2; i >= 0; i--)
         b[i] = b[i+1] ^ g[i];
      return b;
   endfunction : gray2bin

   function automatic aps_mode_e mode_after(input aps_mode_e m, input logic [APS_CNT_W-1:0] n);
      aps_mode_e r;
      r = m;
      if (n >= APS_EDGE_KEEP)
         r = APS_NORMAL;
      else if (n >= APS_EDGE_MIN)
         r = (m == APS_NORMAL) ? APS_PARTIAL : APS_FULL;
      return r;
   endfunction : mode_after

   // ==========================================================
   // Link side and crossings
   logic [APS_WORD_W-1:0] word_r;
   logic [APS_CNT_W-1:0] link_gray;
   logic [APS_CNT_W-1:0] gray_s;
   logic [1:0] pins_s;
   logic cs_s;
   logic sclk_s;

   aps_link u_link (
      .i_sclk(i_sclk),
      .i_cs_b(i_cs_b),
      .i_word(word_r),
      .o_cnt_gray(link_gray),
      .o_sdo(o_serial_result_out)
   );

   // Select idles high; a low reset value here would fake a frame start after reset
   aps_sync #(.W(2), .RST_VAL(2'h2)) u_pin_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_cs_b, i_sclk}),
      .o_q(pins_s)
   );

   aps_sync #(.W(APS_CNT_W)) u_cnt_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d(link_gray),
      .o_q(gray_s)
   );

   assign cs_s = pins_s[1];
   assign sclk_s = pins_s[0];

   // ==========================================================
   // Edge detection on synchronised pins
   logic cs_d_r;
   logic sclk_d_r;
   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_any;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cs_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
      end
      else
      begin
         cs_d_r <= cs_s;
         sclk_d_r <= sclk_s;
      end
   end

   assign cs_fall = cs_d_r & ~cs_s;
   assign cs_rise = ~cs_d_r & cs_s;
   assign sclk_rise = ~sclk_d_r & sclk_s;
   assign sclk_any = sclk_d_r ^ sclk_s;

   // ==========================================================
   // Falling edges seen in this frame
   // The count is read one cycle late and only while select is low, so the
   // asynchronous clear at select rise cannot shorten a frame's tally.
   logic [APS_CNT_W-1:0] cnt_prev_r;
   logic [APS_CNT_W-1:0] edges_r;
   logic frame_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_prev_r <= '0;
      else
         cnt_prev_r <= gray2bin(gray_s);
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         edges_r <= '0;
      else if (cs_fall)
         edges_r <= '0;
      else if (!cs_s && cnt_prev_r > edges_r)
         edges_r <= cnt_prev_r;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         frame_r <= 1'b0;
      else if (cs_fall)
         frame_r <= 1'b1;
      else if (cs_rise)
         frame_r <= 1'b0;
   end

   // ==========================================================
   // Mode register
   aps_mode_e mode_r;
   aps_mode_e mode_nxt;
   aps_mode_e start_mode_r;

   assign mode_nxt = mode_after(mode_r, edges_r);

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         mode_r <= POWERON_MODE;
      else if (cs_rise)
         mode_r <= mode_nxt;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         start_mode_r <= POWERON_MODE;
      else if (cs_fall)
         start_mode_r <= mode_r;
   end

   // ==========================================================
   // Analog power and wake timing
   // Wake timing starts at select fall, as the analog side does.
   logic analog_on_r;
   logic [APS_WAKE_W-1:0] wake_cnt_r;
   logic ready_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         analog_on_r <= (POWERON_MODE == APS_NORMAL);
      else if (cs_fall)
         analog_on_r <= 1'b1;
      else if (cs_rise)
         analog_on_r <= (mode_nxt == APS_NORMAL);
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         wake_cnt_r <= '0;
      else if (cs_fall && mode_r == APS_PARTIAL)
         wake_cnt_r <= APS_WAKE_W'(APS_PART_WAKE_CYC);
      else if (cs_fall && mode_r == APS_FULL)
         wake_cnt_r <= APS_WAKE_W'(FULL_WAKE_CYC);
      else if (cs_rise && mode_nxt != APS_NORMAL)
         wake_cnt_r <= '0;
      else if (wake_cnt_r != '0)
         wake_cnt_r <= wake_cnt_r - 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         ready_r <= (POWERON_MODE == APS_NORMAL);
      else
         ready_r <= analog_on_r && wake_cnt_r == '0 && !(frame_r && start_mode_r != APS_NORMAL);
   end

   // A frame's data count only if it began fully powered
   logic frame_ok_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         frame_ok_r <= 1'b0;
      else if (cs_fall)
         frame_ok_r <= ready_r && mode_r == APS_NORMAL;
   end

   // ==========================================================
   // Track-and-hold
   logic track_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         track_r <= 1'b1;
      else if (cs_fall)
         track_r <= 1'b0;
      else if (cs_rise)
         track_r <= (mode_nxt == APS_NORMAL);
      else if (frame_r && start_mode_r != APS_NORMAL && sclk_any)
         track_r <= 1'b1;
      else if (frame_r && edges_r >= APS_EDGE_TRACK && sclk_rise)
         track_r <= 1'b1;
   end

   // ==========================================================
   // Output enable, result word, event pulses
   logic oe_r;
   logic sample_r;
   logic abort_r;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         oe_r <= 1'b0;
      else if (cs_rise)
         oe_r <= 1'b0;
      else if (cs_fall)
         oe_r <= 1'b1;
      else if (frame_r && edges_r == APS_EDGE_FRAME)
         oe_r <= 1'b0;
   end

   // Held still while select is low so the link reads a quiet word
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         word_r <= '0;
      else if (cs_s && !frame_r)
         word_r <= {APS_LEAD_ZEROS, i_result};
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sample_r <= 1'b0;
         abort_r <= 1'b0;
      end
      else
      begin
         sample_r <= cs_fall;
         abort_r <= cs_rise && edges_r < APS_EDGE_FRAME;
      end
   end

   assign o_serial_result_oe = oe_r;
   assign o_sample = sample_r;
   assign o_abort = abort_r;
   assign o_status = '{mode: mode_r, analog_on: analog_on_r, track: track_r, ready: ready_r,
                       frame_ok: frame_ok_r};

   // ==========================================================
   // Checks
   a_sample_on_fall: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_fall |=> o_sample && !o_status.track && o_serial_result_oe)
      else $error("select fall did not start a frame");

   a_glitch_keeps_mode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && edges_r < APS_EDGE_MIN |=> mode_r == $past(mode_r))
      else $error("short select pulse changed the mode");

   a_normal_to_partial: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && mode_r == APS_NORMAL && edges_r >= APS_EDGE_MIN && edges_r < APS_EDGE_KEEP
      |=> mode_r == APS_PARTIAL && !o_serial_result_oe && !analog_on_r)
      else $error("normal frame cut early missed partial power-down");

   a_partial_to_full: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && mode_r == APS_PARTIAL && edges_r >= APS_EDGE_MIN && edges_r < APS_EDGE_KEEP
      |=> mode_r == APS_FULL)
      else $error("partial frame cut early missed full power-down");

   a_long_frame_powered: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && edges_r >= APS_EDGE_KEEP |=> mode_r == APS_NORMAL && analog_on_r)
      else $error("frame past edge ten did not leave device powered");

   a_abort_floats: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_rise && edges_r < APS_EDGE_FRAME |=> o_abort && !o_serial_result_oe)
      else $error("early select rise did not abort and float");

   a_float_at_end: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      frame_r && !cs_rise && edges_r == APS_EDGE_FRAME |=> !o_serial_result_oe)
      else $error("output still driven after sixteenth edge");

   a_track_after_13: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      frame_r && !cs_rise && !cs_fall && edges_r >= APS_EDGE_TRACK && sclk_rise |=> o_status.track)
      else $error("track not resumed after thirteenth edge");

   a_partial_wake_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      cs_fall && mode_r == APS_PARTIAL ##1 (!cs_s && !cs_rise) [*8]
      |-> ##[1:130] (wake_cnt_r == '0))
      else $error("partial wake took longer than expected");

   a_three_modes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      mode_r inside {APS_NORMAL, APS_PARTIAL, APS_FULL})
      else $error("illegal mode code");
endmodule : aps_top

// ### test/aps_host.sv
// Host model: drives select and serial clock, reads serial result word
`timescale 1ns/10ps
module aps_host (
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_cs_b
);
   // ==========================================================
   // Serial clock stands high between frames
   initial
   begin
      o_sclk = 1'b1;
      o_cs_b = 1'b1;
   end

   // ==========================================================
   // One frame of n falling edges; short frames need no tail clocks
   task automatic frame(input int n, output logic [15:0] word);
      word = 16'h0000;
      @(posedge i_clk);
      o_cs_b <= 1'b0;
      repeat (6) @(posedge i_clk);
      #3;
      word[15] = i_sdo;
      for (int k = 1; k <= n; k++)
      begin
         #40 o_sclk = 1'b0;
         #40 o_sclk = 1'b1;
         if (k <= 15)
            word[15 - k] = i_sdo;
      end
      repeat (4) @(posedge i_clk);
      o_cs_b <= 1'b1;
      // Quiet time before another frame
      repeat (6) @(posedge i_clk);
   endtask : frame
endmodule : aps_host

// ### test/tb.sv
// Self-checking bench for the power-mode sequencer
`timescale 1ns/10ps
module tb;
   import aps_pkg::*;
   typedef struct {int n; aps_mode_e mode; logic abort; logic [11:0] res;} aps_row_s;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic sclk, cs_b, sdo, oe, sample, abort, sdo_wire, sdo_last;
   logic [11:0] res = 12'h000;
   logic [15:0] word;
   aps_status_s st;
   int fails = 0;
   int checked = 0;
   int n_samp = 0;
   int n_abort = 0;
   int s0, a0;
   // Full-wake count shortened so the run stays short, yet longer than one frame
   localparam int WAKE = 400;
   aps_row_s rows [11] = '{
      '{16, APS_NORMAL, 1'b0, 12'ha5c}, '{1, APS_NORMAL, 1'b1, 12'h3c1},
      '{12, APS_NORMAL, 1'b1, 12'h000}, '{5, APS_PARTIAL, 1'b1, 12'h000},
      '{1, APS_PARTIAL, 1'b1, 12'h000}, '{10, APS_NORMAL, 1'b1, 12'h000},
      '{2, APS_PARTIAL, 1'b1, 12'h000}, '{9, APS_FULL, 1'b1, 12'h000},
      '{1, APS_FULL, 1'b1, 12'h000}, '{16, APS_NORMAL, 1'b0, 12'hfff},
      '{16, APS_NORMAL, 1'b0, 12'h801}};

   always #4 i_clk = ~i_clk;
   // Released wire shows the inverse of its last value, never a stale copy
   always @* if (oe === 1'b1) sdo_last = sdo;
   assign sdo_wire = (oe === 1'b1) ? sdo : ~sdo_last;
   always @(posedge i_clk)
   begin
      if (sample === 1'b1) n_samp++;
      if (abort === 1'b1) n_abort++;
   end

   aps_top #(.FULL_WAKE_CYC(WAKE)) aps_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(sclk),
      .i_cs_b(cs_b), .i_result(res), .o_serial_result_out(sdo), .o_serial_result_oe(oe),
      .o_status(st), .o_sample(sample), .o_abort(abort));
   aps_host aps_host_inst (.i_clk(i_clk), .i_sdo(sdo_wire), .o_sclk(sclk), .o_cs_b(cs_b));

   // ==========================================================
   // Compare tasks
   task automatic chk_mode(input aps_mode_e got, input aps_mode_e exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error t=%0t mode %0d expected %0d", $time, got, exp);
      end
   endtask : chk_mode
   task automatic chk_flag(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error t=%0t %s is %b expected %b", $time, what, got, exp);
      end
   endtask : chk_flag
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error t=%0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // Watchdog: about sixty full frames of headroom
   initial
   begin
      #100000;
      fails++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk);
      foreach (rows[i])
      begin
         res <= rows[i].res;
         s0 = n_samp;
         a0 = n_abort;
         aps_host_inst.frame(rows[i].n, word);
         chk_flag(n_samp == s0 + 1, 1'b1, "sample");
         chk_flag(n_abort != a0, rows[i].abort, "abort");
         chk_mode(st.mode, rows[i].mode);
         chk_flag(oe, 1'b0, "oe");
         chk_flag(st.track, rows[i].mode == APS_NORMAL, "track");
         if (rows[i].n == 16)
            chk_word(word, {APS_LEAD_ZEROS, rows[i].res});
         if (i == 9)
         begin
            chk_flag(st.ready, 1'b0, "ready early");
            chk_flag(st.frame_ok, 1'b0, "frame_ok wake");
            repeat (WAKE) @(posedge i_clk);
            chk_flag(st.ready, 1'b1, "ready");
            chk_flag(st.analog_on, 1'b1, "analog_on");
         end
         $display("row %0d done", i);
      end
      // Partial wake finishes within one microsecond
      aps_host_inst.frame(5, word);
      aps_host_inst.frame(10, word);
      chk_flag(st.ready, 1'b0, "ready waking");
      // Counted from select fall; the cut frame has used most of it
      repeat (16) @(posedge i_clk);
      chk_flag(st.ready, 1'b1, "ready partial");
      $display("partial wake done");
      // Reset in power-down: start-up mode, tracking, bus released
      aps_host_inst.frame(5, word);
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk_mode(st.mode, APS_NORMAL);
      chk_flag(st.track, 1'b1, "track reset");
      chk_flag(oe, 1'b0, "oe reset");
      s0 = n_samp;
      a0 = n_abort;
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk);
      res <= 12'h6b7;
      aps_host_inst.frame(16, word);
      chk_word(word, {APS_LEAD_ZEROS, 12'h6b7});
      chk_flag(st.frame_ok, 1'b1, "frame_ok");
      chk_flag(n_samp == s0 + 1, 1'b1, "sample after reset");
      chk_flag(n_abort != a0, 1'b0, "abort after reset");
      $display("reset test done");
      print_verdict();
   end
endmodule : tb
